//--- rtl/audio_bclk_gen.sv
`timescale 1ns/1ps
module audio_bclk_gen (
    // Clock and reset
    input logic clk_in,
    input logic rst_n_in,
    // Control
    input logic run_in,
    input logic [7:0] div_in,
    // Bit clock and its edge pulses
    output logic bclk_out,
    output logic rise_en_out,
    output logic fall_en_out
);
    logic [7:0] cnt_r, cnt_nxt;
    logic bclk_r, bclk_nxt;
    logic rise_r, rise_nxt;
    logic fall_r, fall_nxt;
    logic [7:0] ph_r, ph_nxt;

    // Each phase lasts div+1 cycles, so a period is 2*(div+1)
    always_comb begin
        cnt_nxt = cnt_r + 8'h01;
        bclk_nxt = bclk_r;
        rise_nxt = 1'b0;
        fall_nxt = 1'b0;
        ph_nxt = ph_r + 8'h01;
        if (!run_in) begin
            cnt_nxt = 8'h00;
            bclk_nxt = 1'b0;
            ph_nxt = 8'h00;
        end else if (cnt_r >= div_in) begin
            cnt_nxt = 8'h00;
            bclk_nxt = ~bclk_r;
            rise_nxt = ~bclk_r;
            fall_nxt = bclk_r;
            ph_nxt = 8'h00;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= 8'h00;
            bclk_r <= 1'b0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
            ph_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
            bclk_r <= bclk_nxt;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
            ph_r <= ph_nxt;
        end
    end

    assign bclk_out = bclk_r;
    assign rise_en_out = rise_r;
    assign fall_en_out = fall_r;

    AST_BCLK_PHASE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        run_in && $past(run_in) && $stable(div_in) && $changed(bclk_r) |-> $past(ph_r) == div_in)
        else $error("Bit clock phase length wrong");

endmodule // audio_bclk_gen

//--- rtl/audio_mclk_gen.sv
`timescale 1ns/1ps
module audio_mclk_gen (
    // Clock and reset
    input logic clk_in,
    input logic rst_n_in,
    // Control
    input logic run_in,
    input logic [2:0] div_in,
    // Master clock
    output logic mclk_out
);
    logic [2:0] cnt_r, cnt_nxt;
    logic mclk_r, mclk_nxt;
    logic pass_r, pass_nxt;

    // Toggle every N cycles for a 2N divide; zero selects pass-through
    always_comb begin
        cnt_nxt = cnt_r + 3'h1;
        mclk_nxt = mclk_r;
        pass_nxt = run_in && (div_in == 3'h0);
        if (!run_in || div_in == 3'h0) begin
            cnt_nxt = 3'h0;
            mclk_nxt = 1'b0;
        end else if (cnt_r >= div_in - 3'h1) begin
            cnt_nxt = 3'h0;
            mclk_nxt = ~mclk_r;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= 3'h0;
            mclk_r <= 1'b0;
            pass_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            mclk_r <= mclk_nxt;
            pass_r <= pass_nxt;
        end
    end

    // Pass-through cannot come from a flop; the select itself is registered
    assign mclk_out = pass_r ? clk_in : mclk_r;

    AST_MCLK_PASS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        run_in && div_in == 3'h0 |=> pass_r)
        else $error("Master clock not passed through");
    AST_MCLK_DIV4: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        run_in && div_in == 3'h2 && $past(div_in) == 3'h2 && $changed(mclk_r) && $past(run_in)
        |=> $stable(mclk_r) ##1 ($changed(mclk_r) || !run_in || div_in != 3'h2))
        else $error("Master clock divide by four wrong");

endmodule // audio_mclk_gen

//--- rtl/audio_port_pkg.sv
package audio_port_pkg;

    // Sample width codes
    typedef enum logic [1:0] {
        WID_8 = 2'h0,
        WID_16 = 2'h1,
        WID_24 = 2'h2,
        WID_32 = 2'h3
    } width_t;

    // Link sequencer states
    typedef enum logic {
        ST_IDLE = 1'h0,
        ST_RUN = 1'h1
    } link_state_t;

endpackage

//--- rtl/audio_port_regs.svh
`ifndef AUDIO_PORT_REGS_SVH
`define AUDIO_PORT_REGS_SVH

// Register offsets
`define AP_CTRL_OFS 8'h00
`define AP_CLKDIV_OFS 8'h04
`define AP_STAT_OFS 8'h10

// Reset values
`define AP_CTRL_RST 8'h00
`define AP_BDIV_RST 8'h00
`define AP_MDIV_RST 3'h0

// Control field positions
`define AP_FMT_BIT 7
`define AP_MONO_BIT 6
`define AP_WID_HI 5
`define AP_WID_LO 4
`define AP_MUTE_BIT 3
`define AP_RECEIVE_ENABLE_BIT_BIT 2
`define AP_TRANSMIT_ENABLE_BIT_BIT 1
`define AP_PEN_BIT 0

// Clock divider field positions
`define AP_BDIV_HI 15
`define AP_BDIV_LO 8
`define AP_MDIV_HI 2
`define AP_MDIV_LO 0

`endif

//--- rtl/audio_serial_port.sv
`timescale 1ns/1ps
`include "audio_port_regs.svh"

// How it works
// - Format bit one selects MSB-justified framing
// - Format bit zero selects standard I2S framing
// - Mono bit selects mono or stereo packing
// - Width code picks 8/16/24/32 bit samples
// - Mute sends zeros instead of stream words
// - Receive enable gates incoming sample capture
// - Transmit enable gates outgoing sample data
// - Port enable switches clocks and link on/off; holding register still takes one word
// - Divider register at 0x04, resets zero
// - Bit clock is input over 2*(div+1)
// - Master divide zero passes, else 2N
module audio_serial_port #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input logic ref_clk_in,
    input logic rstn_in,
    // Register port
    input logic [ADDR_W-1:0] addr_in,
    input logic [31:0] wdata_in,
    input logic wr_in,
    input logic rd_in,
    output logic [31:0] rdata_out,
    // Transmit stream
    input logic [31:0] tx_data_in,
    input logic tx_valid_in,
    output logic tx_ready_out,
    // Receive stream
    output logic [31:0] rx_data_out,
    output logic rx_valid_out,
    output logic rx_right_out,
    // Serial link to codec
    output logic bclk_out,
    output logic fs_out,
    output logic sdo_out,
    input logic sdi_in,
    output logic mclk_out
);
    // Reset release and input synchronisers
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic sdi_meta_r, sdi_sync_r;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sdi_meta_r <= 1'b0;
            sdi_sync_r <= 1'b0;
        end else begin
            sdi_meta_r <= sdi_in;
            sdi_sync_r <= sdi_meta_r;
        end
    end

    // Address match, shared by writes and reads
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    // Sample width in bits
    function automatic logic [5:0] width_bits(input audio_port_pkg::width_t w);
        case (w)
            audio_port_pkg::WID_8: width_bits = 6'h08;
            audio_port_pkg::WID_16: width_bits = 6'h10;
            audio_port_pkg::WID_24: width_bits = 6'h18;
            default: width_bits = 6'h20;
        endcase
    endfunction

    // Register state
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] bdiv_r, bdiv_nxt;
    logic [2:0] mdiv_r, mdiv_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // Link state
    audio_port_pkg::link_state_t st_r, st_nxt;
    logic [5:0] bit_r, bit_nxt;
    logic ch_r, ch_nxt;
    logic fs_r, fs_nxt;
    logic sdo_r, sdo_nxt;
    logic [31:0] tx_sh_r, tx_sh_nxt;
    logic [31:0] mono_r, mono_nxt;
    logic [31:0] hold_r, hold_nxt;
    logic full_r, full_nxt;
    logic ready_r, ready_nxt;
    logic [31:0] rx_sh_r, rx_sh_nxt;
    logic [31:0] rxd_r, rxd_nxt;
    logic rxv_r, rxv_nxt;
    logic rxr_r, rxr_nxt;

    // Decoded control fields
    logic port_en, tx_on, rx_on, msb_just, mono, mute;
    audio_port_pkg::width_t wsel;
    logic [5:0] wbits, wlast;
    logic [31:0] wmask;
    logic rise_en, fall_en, bclk;

    assign port_en = ctrl_r[`AP_PEN_BIT];
    assign tx_on = port_en && ctrl_r[`AP_TRANSMIT_ENABLE_BIT_BIT];
    assign rx_on = port_en && ctrl_r[`AP_RECEIVE_ENABLE_BIT_BIT];
    assign msb_just = ctrl_r[`AP_FMT_BIT];
    assign mono = ctrl_r[`AP_MONO_BIT];
    assign mute = ctrl_r[`AP_MUTE_BIT];
    assign wsel = audio_port_pkg::width_t'(ctrl_r[`AP_WID_HI:`AP_WID_LO]);
    assign wbits = width_bits(wsel);
    assign wlast = wbits - 6'h01;
    assign wmask = ~(32'hFFFF_FFFF << wbits);

    // Register writes and one-cycle read data; unmapped reads give zero
    always_comb begin
        ctrl_nxt = ctrl_r;
        bdiv_nxt = bdiv_r;
        mdiv_nxt = mdiv_r;
        rdata_nxt = 32'h0000_0000;
        if (wr_in && hit(addr_in, `AP_CTRL_OFS)) begin
            ctrl_nxt = wdata_in[7:0];
        end
        if (wr_in && hit(addr_in, `AP_CLKDIV_OFS)) begin
            bdiv_nxt = wdata_in[`AP_BDIV_HI:`AP_BDIV_LO];
            mdiv_nxt = wdata_in[`AP_MDIV_HI:`AP_MDIV_LO];
        end
        if (rd_in && hit(addr_in, `AP_CTRL_OFS)) begin
            rdata_nxt = {24'h00_0000, ctrl_r};
        end else if (rd_in && hit(addr_in, `AP_CLKDIV_OFS)) begin
            rdata_nxt = {16'h0000, bdiv_r, 5'h00, mdiv_r};
        end else if (rd_in && hit(addr_in, `AP_STAT_OFS)) begin
            rdata_nxt = {20'h0_0000, full_r, st_r == audio_port_pkg::ST_RUN, fs_r, ch_r, 2'h0, bit_r};
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `AP_CTRL_RST;
            bdiv_r <= `AP_BDIV_RST;
            mdiv_r <= `AP_MDIV_RST;
            rdata_r <= 32'h0000_0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            bdiv_r <= bdiv_nxt;
            mdiv_r <= mdiv_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Clock generators run only while the port is enabled
    audio_bclk_gen u_bclk (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .run_in(port_en),
        .div_in(bdiv_r),
        .bclk_out(bclk),
        .rise_en_out(rise_en),
        .fall_en_out(fall_en)
    );

    audio_mclk_gen u_mclk (
        .clk_in(ref_clk_in),
        .rst_n_in(rst_n),
        .run_in(port_en),
        .div_in(mdiv_r),
        .mclk_out(mclk_out)
    );

    // Frame position helpers
    logic last_bit, adv_ch, load_ev, rx_done;
    logic [5:0] adv_bit;
    logic [31:0] load_word, rx_word;

    assign last_bit = bit_r >= wlast; // Width shrunk mid-slot also ends it
    assign adv_bit = last_bit ? 6'h00 : bit_r + 6'h01;
    assign adv_ch = last_bit ? ~ch_r : ch_r;
    assign load_ev = (st_r == audio_port_pkg::ST_RUN) && port_en && fall_en && (adv_bit == 6'h00);
    assign rx_word = {rx_sh_r[30:0], sdi_sync_r} & wmask;
    assign rx_done = rise_en && rx_on && last_bit && !(mono && ch_r);

    // Word to shift at the start of a slot; words are MSB aligned for shifting
    always_comb begin
        load_word = 32'h0000_0000;
        if (!tx_on || mute) begin
            load_word = 32'h0000_0000;
        end else if (mono && adv_ch) begin
            load_word = mono_r;
        end else if (full_r) begin
            load_word = hold_r << (6'h20 - wbits);
        end
    end

    // Sequencer: bits change on bit clock falls, sampled on rises
    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        ch_nxt = ch_r;
        fs_nxt = fs_r;
        sdo_nxt = sdo_r;
        tx_sh_nxt = tx_sh_r;
        mono_nxt = mono_r;
        hold_nxt = hold_r;
        full_nxt = full_r;
        rx_sh_nxt = rx_sh_r;
        rxd_nxt = rxd_r;
        rxv_nxt = 1'b0;
        rxr_nxt = rxr_r;
        if (tx_valid_in && ready_r) begin
            hold_nxt = tx_data_in;
            full_nxt = 1'b1;
        end
        case (st_r)
            audio_port_pkg::ST_IDLE: begin
                bit_nxt = wlast; // First fall lands on left bit 0
                ch_nxt = 1'b1;
                fs_nxt = 1'b0;
                sdo_nxt = 1'b0;
                if (port_en) begin
                    st_nxt = audio_port_pkg::ST_RUN;
                end
            end
            audio_port_pkg::ST_RUN: begin
                if (!port_en) begin
                    st_nxt = audio_port_pkg::ST_IDLE;
                end else begin
                    if (rise_en && rx_on) begin
                        rx_sh_nxt = {rx_sh_r[30:0], sdi_sync_r};
                    end
                    if (rx_done) begin
                        rxd_nxt = rx_word;
                        rxv_nxt = 1'b1;
                        rxr_nxt = ch_r;
                    end
                    if (fall_en) begin
                        bit_nxt = adv_bit;
                        ch_nxt = adv_ch;
                        if (msb_just) begin
                            fs_nxt = adv_ch;
                        end else begin
                            fs_nxt = (adv_bit >= wlast) ? ~adv_ch : adv_ch;
                        end
                        if (adv_bit == 6'h00) begin
                            sdo_nxt = load_word[31];
                            tx_sh_nxt = {load_word[30:0], 1'b0};
                            if (tx_on && !mute && !(mono && adv_ch) && full_r) begin
                                full_nxt = 1'b0;
                                mono_nxt = load_word;
                            end
                        end else begin
                            sdo_nxt = tx_sh_r[31];
                            tx_sh_nxt = {tx_sh_r[30:0], 1'b0};
                        end
                    end
                end
            end
            default: begin
                st_nxt = audio_port_pkg::ST_IDLE;
            end
        endcase
        ready_nxt = !full_nxt; // Single holding word back-pressures the source
    end

    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= audio_port_pkg::ST_IDLE;
            bit_r <= 6'h00;
            ch_r <= 1'b0;
            fs_r <= 1'b0;
            sdo_r <= 1'b0;
            tx_sh_r <= 32'h0000_0000;
            mono_r <= 32'h0000_0000;
            hold_r <= 32'h0000_0000;
            full_r <= 1'b0;
            ready_r <= 1'b0;
            rx_sh_r <= 32'h0000_0000;
            rxd_r <= 32'h0000_0000;
            rxv_r <= 1'b0;
            rxr_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            ch_r <= ch_nxt;
            fs_r <= fs_nxt;
            sdo_r <= sdo_nxt;
            tx_sh_r <= tx_sh_nxt;
            mono_r <= mono_nxt;
            hold_r <= hold_nxt;
            full_r <= full_nxt;
            ready_r <= ready_nxt;
            rx_sh_r <= rx_sh_nxt;
            rxd_r <= rxd_nxt;
            rxv_r <= rxv_nxt;
            rxr_r <= rxr_nxt;
        end
    end

    // Outputs straight from flops
    assign rdata_out = rdata_r;
    assign tx_ready_out = ready_r;
    assign rx_data_out = rxd_r;
    assign rx_valid_out = rxv_r;
    assign rx_right_out = rxr_r;
    assign bclk_out = bclk;
    assign fs_out = fs_r;
    assign sdo_out = sdo_r;

    // Checks
    AST_MSB_FS: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        st_r == audio_port_pkg::ST_RUN && port_en && fall_en && msb_just |=> fs_r == ch_r)
        else $error("MSB justified frame sync not aligned to slot");
    AST_I2S_FS: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        load_ev && !msb_just && $stable(ctrl_r) && bit_r != 6'h00 |-> fs_r == adv_ch)
        else $error("I2S frame sync does not lead slot by one bit");
    AST_MONO_RX: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        $rose(rxv_r) && $past(mono) |-> !rxr_r)
        else $error("Right word received in mono mode");
    AST_RX_WIDTH: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        rx_done && $stable(ctrl_r) |=> rxv_r && (rxd_r & ~$past(wmask)) == 32'h0000_0000)
        else $error("Received word wider than selected width");
    AST_MUTE: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        load_ev && mute |=> !sdo_r && tx_sh_r == 32'h0000_0000)
        else $error("Muted slot carries data");
    AST_RX_OFF: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        !rx_on |=> !rxv_r)
        else $error("Word received while receive disabled");
    AST_TX_OFF: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        load_ev && !tx_on && full_r |=> !sdo_r && full_r)
        else $error("Word sent while transmit disabled");
    AST_PORT_OFF: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        !port_en [*2] |=> !sdo_r && !fs_r && !bclk && st_r == audio_port_pkg::ST_IDLE)
        else $error("Link active while port disabled");
    AST_DIV_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        rd_in && hit(addr_in, `AP_CLKDIV_OFS) |=> rdata_r == {16'h0000, $past(bdiv_r), 5'h00, $past(mdiv_r)})
        else $error("Divider register read wrong");
    AST_IDLE_PATHS: assert property (@(posedge ref_clk_in) disable iff (!rst_n)
        !port_en && (ctrl_r[`AP_TRANSMIT_ENABLE_BIT_BIT] || ctrl_r[`AP_RECEIVE_ENABLE_BIT_BIT]) |=> !rxv_r && !$rose(rxv_r))
        else $error("Path active with port disabled");

endmodule // audio_serial_port

//--- verification/audio_codec_model.sv
`timescale 1ns/1ps
// Codec slave on the serial link: it frames both data lines as the port is set up
// and feeds the port a pseudo-random bit pattern, one new bit on every bit clock fall
module audio_codec_model (
    // Serial link
    input wire logic bclk_in,
    input wire logic fs_in,
    input wire logic sdo_in,
    output logic sdi_out,
    // Codec setup
    input wire logic fmt_in,
    input wire logic [1:0] wid_in,
    input wire logic flush_in
);
    logic [32:0] txq[$];
    logic [32:0] rxq[$];
    logic [31:0] tx_sh;
    logic [31:0] rx_sh;
    logic [15:0] lfsr = 16'h0001;
    logic fs_q;
    logic chan;
    logic synced;
    logic bnd;
    int cnt;
    int w;

    initial sdi_out = 1'b0;

    // Send on the falling edge so the line is settled when the port samples at the rise
    always @(negedge bclk_in) begin
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        sdi_out <= lfsr[15];
    end

    // Words are recorded only after a sync change; the first slot is ambiguous
    always @(posedge bclk_in or posedge flush_in) begin
        if (flush_in) begin
            cnt = 0;
            synced = 1'b0;
            fs_q = 1'b0;
            txq.delete();
            rxq.delete();
        end else begin
            w = 8 * (int'(wid_in) + 1);
            bnd = fs_in != fs_q;
            fs_q = fs_in;
            if (bnd && fmt_in) begin // MSB arrives with the sync change
                cnt = 0;
                synced = 1'b1;
            end
            if (cnt == 0) begin
                chan = fs_in;
            end
            tx_sh = {tx_sh[30:0], sdo_in};
            rx_sh = {rx_sh[30:0], sdi_out};
            cnt++;
            if (cnt == w) begin
                if (synced) begin
                    txq.push_back({chan, tx_sh & 32'((64'h1 << w) - 64'h1)});
                    rxq.push_back({chan, rx_sh & 32'((64'h1 << w) - 64'h1)});
                end
                cnt = 0;
            end
            if (bnd && !fmt_in) begin // Sync change leads the MSB by one bit
                cnt = 0;
                synced = 1'b1;
            end
        end
    end
endmodule // audio_codec_model

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [31:0] rdata_out;
    logic [31:0] tx_data_in = 32'h0000_0000;
    logic tx_valid_in = 1'b0;
    logic tx_ready_out;
    logic [31:0] rx_data_out;
    logic rx_valid_out;
    logic rx_right_out;
    logic bclk_out;
    logic fs_out;
    logic sdo_out;
    logic sdi_in;
    logic mclk_out;
    logic cfg_fmt = 1'b0;
    logic [1:0] cfg_w = 2'h0;
    logic cfg_mono = 1'b0;
    logic flush = 1'b0;
    logic tx_on = 1'b0;
    logic [32:0] expq[$];
    logic [32:0] dq[$];
    logic [32:0] ref_rx[$];
    logic [7:0] bvals[4];
    logic [7:0] bdiv;
    int push_cnt = 0;
    int error_cnt = 0;
    int checks = 0;
    int seed = 76;
    int n;

    always #2.5 ref_clk_in = ~ref_clk_in;

    audio_serial_port DUT (
        .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .tx_data_in(tx_data_in),
        .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out), .rx_data_out(rx_data_out),
        .rx_valid_out(rx_valid_out), .rx_right_out(rx_right_out), .bclk_out(bclk_out),
        .fs_out(fs_out), .sdo_out(sdo_out), .sdi_in(sdi_in), .mclk_out(mclk_out)
    );

    audio_codec_model PEER (
        .bclk_in(bclk_out), .fs_in(fs_out), .sdo_in(sdo_out), .sdi_out(sdi_in),
        .fmt_in(cfg_fmt), .wid_in(cfg_w), .flush_in(flush)
    );

    function automatic logic [31:0] wmask(input logic [1:0] w);
        return 32'((64'h1 << (8 * (int'(w) + 1))) - 64'h1);
    endfunction

    // Mismatches after lining b up with a; short or unmatched lists count as broken
    function automatic int align(input logic [32:0] a[$], input logic [32:0] b[$]);
        int j;
        int bad;
        j = -1;
        bad = 0;
        for (int k = 0; k < 4; k++) begin
            if (j < 0 && a.size() > 1 && k + 1 < b.size() && b[k] === a[0] && b[k + 1] === a[1]) begin
                j = k;
            end
        end
        if (j < 0 || a.size() < 6) begin
            return 99;
        end
        for (int i = 0; i < a.size() && i + j < b.size(); i++) begin
            bad += int'(a[i] !== b[i + j]);
        end
        return bad;
    endfunction

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask

    // Read data only stands in the cycle after the strobe
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1;
        check(name, 64'(rdata_out), 64'(exp));
    endtask

    // Cycles between two rises of the bit clock or master clock
    task automatic meas(input logic which, output int p);
        int edges;
        logic prev;
        logic cur;
        edges = 0;
        p = 0;
        prev = 1'b1;
        for (int t = 0; t < 2000 && edges < 2; t++) begin
            @(posedge ref_clk_in);
            #1;
            cur = which ? mclk_out : bclk_out;
            p += int'(edges == 1);
            edges += int'(cur === 1'b1 && prev === 1'b0);
            prev = cur;
        end
    endtask

    task automatic watch(input int cycles, output int rises, output int rxp, output int ones);
        logic prev;
        rises = 0;
        rxp = 0;
        ones = 0;
        prev = bclk_out;
        repeat (cycles) begin
            @(posedge ref_clk_in);
            #1;
            rises += int'(bclk_out === 1'b1 && prev === 1'b0);
            rxp += int'(rx_valid_out === 1'b1);
            ones += int'(sdo_out === 1'b1);
            prev = bclk_out;
        end
    endtask

    // Source holds an offered word until taken; sink logs each received word
    always @(posedge ref_clk_in) begin
        if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
            if (cfg_mono) begin
                expq.push_back({1'b0, tx_data_in & wmask(cfg_w)});
                expq.push_back({1'b1, tx_data_in & wmask(cfg_w)});
            end else begin
                expq.push_back({push_cnt[0], tx_data_in & wmask(cfg_w)});
            end
            push_cnt++;
            tx_data_in <= $random(seed);
        end
        tx_valid_in <= tx_on || (tx_valid_in && !(tx_ready_out === 1'b1));
        if (rx_valid_out === 1'b1) begin
            dq.push_back({rx_right_out, rx_data_out});
        end
    end

    // One format: held off first, then eight frames of traffic both ways
    task automatic traffic(input logic f, input logic [1:0] w, input logic m);
        logic [31:0] ctrl;
        int rises;
        int rxp;
        int ones;
        int t;
        ctrl = {24'h00_0000, f, m, w, 4'h6};
        reg_write(8'h00, 32'h0000_0000);
        bdiv = 8'h02 + 8'($random(seed) & 1);
        cfg_fmt <= f;
        cfg_w <= w;
        cfg_mono <= m;
        flush <= 1'b1;
        reg_write(8'h04, {16'h0000, bdiv, 8'h00});
        flush <= 1'b0;
        push_cnt = 0;
        expq.delete();
        dq.delete();
        reg_write(8'h00, ctrl);
        tx_on <= 1'b1;
        watch(200, rises, rxp, ones);
        check("bit clock edges while off", 64'(rises), 64'h0);
        check("words taken while off", 64'(push_cnt), 64'h1);
        check("received while off", 64'(rxp), 64'h0);
        reg_write(8'h00, ctrl | 32'h0000_0001);
        repeat (16 * (int'(w) + 1) * 16 * (int'(bdiv) + 1)) @(posedge ref_clk_in);
        tx_on <= 1'b0;
        t = 0;
        while (t < 2000 && !(tx_valid_in === 1'b0 && tx_ready_out === 1'b1)) begin
            @(posedge ref_clk_in);
            #1;
            t++;
        end
        check("transmit drain", 64'(t < 2000), 64'h1);
        reg_write(8'h00, 32'h0000_0000);
        ref_rx.delete();
        foreach (PEER.rxq[i]) begin
            if (!m || !PEER.rxq[i][32]) begin
                ref_rx.push_back(PEER.rxq[i]);
            end
        end
        check("sent words", 64'(align(PEER.txq, expq)), 64'h0);
        check("received words", 64'(align(ref_rx, dq)), 64'h0);
    endtask

    // Port running with transmit silenced; the line must stay at zero
    task automatic quiet(input logic [31:0] ctrl, input int taken, input int rx_exp);
        int rises;
        int rxp;
        int ones;
        reg_write(8'h00, 32'h0000_0000);
        push_cnt = 0;
        reg_write(8'h00, ctrl);
        tx_on <= 1'b1;
        watch(2000, rises, rxp, ones);
        check("serial ones while silent", 64'(ones), 64'h0);
        check("words taken while silent", 64'(push_cnt), 64'(taken));
        check("receive activity", 64'(rxp > 0), 64'(rx_exp));
        check("bit clock running", 64'(rises > 0), 64'h1);
    endtask

    // Main sequence
    initial begin
        bvals = '{8'h00, 8'h01, 8'h05, 8'hFF};
        bvals[2] = 8'h02 + 8'($random(seed) & 8'h1F);
        repeat (8) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        rd_chk("control reset", 8'h00, 32'h0000_0000);
        rd_chk("divider reset", 8'h04, 32'h0000_0000);
        reg_write(8'h04, 32'hFFFF_FFFF);
        rd_chk("divider fields", 8'h04, 32'h0000_FF07);
        reg_write(8'h08, 32'hFFFF_FFFF);
        rd_chk("unmapped read", 8'h08, 32'h0000_0000);
        reg_write(8'h00, 32'hFFFF_FFFE);
        rd_chk("control fields", 8'h00, 32'h0000_00FE);
        foreach (bvals[i]) begin
            reg_write(8'h00, 32'h0000_0000);
            reg_write(8'h04, {16'h0000, bvals[i], 8'h00});
            reg_write(8'h00, 32'h0000_0001);
            meas(1'b0, n);
            check("bit clock period", 64'(n), 64'(2 * (int'(bvals[i]) + 1)));
        end
        for (int k = 1; k < 8; k++) begin
            reg_write(8'h00, 32'h0000_0000);
            reg_write(8'h04, {16'h0000, 8'h02, 5'h00, 3'(k)});
            reg_write(8'h00, 32'h0000_0001);
            meas(1'b1, n);
            check("master clock period", 64'(n), 64'(2 * k));
        end
        reg_write(8'h04, 32'h0000_0200);
        repeat (4) @(posedge ref_clk_in);
        #1;
        check("master clock high phase", 64'(mclk_out), 64'h1);
        @(negedge ref_clk_in);
        #1;
        check("master clock low phase", 64'(mclk_out), 64'h0);
        for (int c = 0; c < 8; c++) begin
            traffic(c[2], c[1:0], c[0] ^ c[1]);
        end
        quiet(32'h0000_003B, 1, 0);
        quiet(32'h0000_0015, 0, 1);
        print_verdict();
    end

    // Watchdog well past the run length
    initial begin
        #300000;
        error_cnt++;
        print_verdict();
    end
endmodule // tb
